/* File: logic/sample_fifo.sv */
// result fifo of flip-flops with valid and ready on both sides
`timescale 1ns/1ps
module sample_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_CNT = DEPTH[AW:0];
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign in_ready  = (count != FULL_CNT);
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

/* File: logic/sar_adc_convert_read_handshake.sv */
// convert start, busy and parallel read handshake of the converter
//
// Functional notes
// RL1 - busy rises within the rise bound after convert_start_n falls; the code refuses a start while no fifo room is left, and busy stays low.
// RL2 - busy drops within the drop bound of the internal end of conversion.
// RL3 - busy stays high no longer than the conversion time per conversion.
// RL4 - the host leaves the acquisition interval between conversions.
// RL5 - the host holds convert_start_n low for the minimum pulse width.
// RL6 - the host holds convert_start_n high for the minimum between pulses.
// RL7 - the host asserts chip select before lowering convert_start_n.
// RL8 - the host waits after a start before any read or selector change.
// RL9 - the host never lowers the read strobe before chip select.
// RL10 - the host keeps the read strobe low and high for the minimum widths.
// RL11 - data is driven within the enable bound of read or chip select low.
// RL12 - data stays driven a hold time after the read strobe rises.
// RL13 - a selector change shows the new data within the selector bound.
// RL14 - a start or chip select fall in the abort window ends a conversion.
// RL15 - the result is put on the bus whole or in portions per the selectors.
`timescale 1ns/1ps
module sar_adc_convert_read_handshake #(
    parameter int RESULT_W = sar_pkg::RESULT_W,
    parameter int DEPTH    = sar_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                clk_sys,
    input  wire logic                rst_n,
    // host strobes and selectors
    input  wire logic                convert_start_n,
    input  wire logic                cs_n,
    input  wire logic                rd_n,
    input  wire logic                byte_sel,
    input  wire logic                bus_width_select,
    // converter core sample
    input  wire logic [RESULT_W-1:0] sample_data,
    // status and data bus
    output logic                     busy,
    output logic      [RESULT_W-1:0] data_out,
    output logic                     data_oe
);
    sar_pkg::pins_t      pins_raw;
    logic [sar_pkg::PINS_W-1:0] sync1;
    logic [sar_pkg::PINS_W-1:0] sync2;
    sar_pkg::pins_t      pins_s;
    logic                cv_prev;
    logic                cs_prev;
    logic                start_fall;
    logic                cs_fall;
    logic                cs_rise;
    logic                rd_act;
    sar_pkg::conv_state_t state;
    logic [sar_pkg::CNT_W-1:0] conv_cnt;
    logic                abort;
    logic                eoc;
    logic                accept;
    logic                fifo_in_ready;
    logic                fifo_out_valid;
    logic [RESULT_W-1:0] fifo_out_data;
    logic                fifo_out_ready;
    logic [RESULT_W-1:0] held;
    logic                held_valid;
    logic                read_seen;
    logic [1:0]          hold_cnt;
    logic [RESULT_W-1:0] next_data;

    localparam logic [sar_pkg::CNT_W-1:0] CONV_END =
        sar_pkg::CONV_CYC[sar_pkg::CNT_W-1:0];
    localparam logic [sar_pkg::CNT_W-1:0] AB_MIN =
        sar_pkg::ABORT_MIN_CYC[sar_pkg::CNT_W-1:0];
    localparam logic [sar_pkg::CNT_W-1:0] AB_MAX =
        sar_pkg::ABORT_MAX_CYC[sar_pkg::CNT_W-1:0];
    localparam logic [1:0] HOLD_LOAD = sar_pkg::DATA_HOLD_CYC[1:0];

    assign pins_raw = '{convert_start_n:  convert_start_n,
                        cs_n:             cs_n,
                        rd_n:             rd_n,
                        sel:              '{bus_width_select: bus_width_select,
                                            byte_sel:         byte_sel}};

    // two flip-flop synchroniser per pin
    genvar gi;
    generate
        for (gi = 0; gi < sar_pkg::PINS_W; gi++) begin : g_sync
            always_ff @(posedge clk_sys) begin
                if (!rst_n) begin
                    sync1[gi] <= 1'b1;
                    sync2[gi] <= 1'b1;
                end else begin
                    sync1[gi] <= pins_raw[gi];
                    sync2[gi] <= sync1[gi];
                end
            end
        end
    endgenerate

    assign pins_s = sync2;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cv_prev <= 1'b1;
            cs_prev <= 1'b1;
        end else begin
            cv_prev <= pins_s.convert_start_n;
            cs_prev <= pins_s.cs_n;
        end
    end

    assign start_fall = cv_prev && !pins_s.convert_start_n;
    assign cs_fall    = cs_prev && !pins_s.cs_n;
    assign cs_rise    = !cs_prev && pins_s.cs_n;
    assign rd_act     = !pins_s.cs_n && !pins_s.rd_n;

    // start refused while no fifo room is left for its result
    assign accept = (state == sar_pkg::ST_IDLE) && start_fall && fifo_in_ready;
    assign abort  = (state == sar_pkg::ST_CONV) &&
                    ((start_fall && !pins_s.cs_n) || cs_fall) &&
                    (conv_cnt >= AB_MIN) && (conv_cnt <= AB_MAX); // [RL14]
    assign eoc    = (state == sar_pkg::ST_CONV) && !abort &&
                    (conv_cnt == CONV_END);

    // conversion sequencer and busy
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state    <= sar_pkg::ST_IDLE;
            conv_cnt <= '0;
            busy     <= sar_pkg::BUSY_RST;
        end else begin
            case (state)
                sar_pkg::ST_IDLE: begin
                    if (accept) begin
                        state    <= sar_pkg::ST_CONV;
                        conv_cnt <= 6'h01;
                        busy     <= 1'b1; // [RL1]
                    end
                end
                sar_pkg::ST_CONV: begin
                    if (abort || eoc) begin
                        state    <= sar_pkg::ST_IDLE;
                        conv_cnt <= '0;
                        busy     <= 1'b0; // [RL2] [RL3] [RL14]
                    end else begin
                        conv_cnt <= conv_cnt + 6'h01;
                    end
                end
                default: begin
                    state    <= sar_pkg::ST_IDLE;
                    conv_cnt <= '0;
                    busy     <= sar_pkg::BUSY_RST;
                end
            endcase
        end
    end

    sample_fifo #(
        .WIDTH (RESULT_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .in_valid  (eoc),
        .in_ready  (fifo_in_ready),
        .in_data   (sample_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    assign fifo_out_ready = !held_valid;

    // word on offer; released when a read frame closes
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            held       <= sar_pkg::DATA_RST;
            held_valid <= 1'b0;
            read_seen  <= 1'b0;
        end else begin
            if (!held_valid && fifo_out_valid) begin
                held       <= fifo_out_data;
                held_valid <= 1'b1;
            end else if (cs_rise && read_seen) begin
                held_valid <= 1'b0;
            end
            if (rd_act) begin
                read_seen <= 1'b1;
            end else if (cs_rise) begin
                read_seen <= 1'b0;
            end
        end
    end

    assign next_data = sar_pkg::map_word(held, pins_s.sel); // [RL15]

    // bus data and enable with hold after the strobe rises
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            data_out <= sar_pkg::DATA_RST;
            data_oe  <= 1'b0;
            hold_cnt <= '0;
        end else begin
            data_out <= next_data; // [RL13] [RL15]
            data_oe  <= rd_act || (hold_cnt != 2'b00); // [RL11] [RL12]
            if (rd_act) begin
                hold_cnt <= HOLD_LOAD;
            end else if (hold_cnt != 2'b00) begin
                hold_cnt <= hold_cnt - 2'b01;
            end
        end
    end

    // assertion helpers
    logic [sar_pkg::CNT_W-1:0] busy_run;
    logic                      rd_act_d;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            busy_run <= '0;
            rd_act_d <= 1'b0;
        end else begin
            busy_run <= busy ? busy_run + 6'h01 : '0;
            rd_act_d <= rd_act;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    busy_rise_a: assert property (accept |-> ##[1:2] busy) // [RL1]
        else $error("busy late after start");
    busy_drop_a: assert property (eoc |=> !busy && fifo_out_valid) // [RL2]
        else $error("busy not dropped at end of conversion");
    busy_len_a: assert property (busy_run <= CONV_END) // [RL3]
        else $error("busy high beyond conversion time");
    data_valid_a: assert property (rd_act |=> data_oe) // [RL11]
        else $error("data not driven on read");
    data_hold_a: assert property (rd_act_d && !rd_act |=> data_oe) // [RL12]
        else $error("data released without hold");
    sel_change_a: assert property ( // [RL13]
        $changed(pins_s.sel) && !$changed(held)
        |=> data_out == sar_pkg::map_word($past(held), $past(pins_s.sel)))
        else $error("selected data not shown");
    abort_end_a: assert property (abort |=> !busy ##1 !busy) // [RL14]
        else $error("abort did not end conversion");
    abort_early_a: assert property ( // [RL14]
        state == sar_pkg::ST_CONV && busy_run < 6'd2 && cs_fall |=> busy)
        else $error("early chip select aborted");
    wide_map_a: assert property ( // [RL15]
        pins_s.sel.bus_width_select && $stable(pins_s.sel)
        |=> data_out == $past(held))
        else $error("full word not on bus");

    conv_done_c: cover property (accept ##[30:34] eoc);
    abort_c:     cover property (accept ##[3:27] abort);
    read_c:      cover property (held_valid ##1 rd_act [*3] ##[1:4] cs_rise);
endmodule

/* File: logic/sar_pkg.sv */
// shared constants, types and mapping for the convert and read handshake
package sar_pkg;
    localparam int CLK_PERIOD_NS = 20;
    localparam int RESULT_W      = 18;
    localparam int FIFO_DEPTH    = 8;
    localparam int CNT_W         = 6;

    // pin timing figures in ns and derived cycle counts
    localparam int T_BUSY_RISE_NS = 40;
    localparam int BUSY_RISE_CYC  = (T_BUSY_RISE_NS / CLK_PERIOD_NS < 1) ? 1 :
                                    T_BUSY_RISE_NS / CLK_PERIOD_NS;
    localparam int T_EOC_DROP_NS  = 15;
    localparam int EOC_DROP_CYC   = (T_EOC_DROP_NS / CLK_PERIOD_NS < 1) ? 1 :
                                    T_EOC_DROP_NS / CLK_PERIOD_NS;
    localparam int T_CONV_NS      = 650;
    localparam int CONV_CYC       = T_CONV_NS / CLK_PERIOD_NS;
    localparam int T_ABORT_MIN_NS = 60;
    localparam int ABORT_MIN_CYC  = (T_ABORT_MIN_NS + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;
    localparam int T_ABORT_MAX_NS = 550;
    localparam int ABORT_MAX_CYC  = T_ABORT_MAX_NS / CLK_PERIOD_NS;
    localparam int T_DATA_HOLD_NS = 5;
    localparam int DATA_HOLD_CYC  = (T_DATA_HOLD_NS + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;
    localparam int T_SEL_MIN_NS   = 10;
    localparam int T_SEL_MAX_NS   = 20;
    localparam int SEL_CYC        = (T_SEL_MAX_NS / CLK_PERIOD_NS < 1) ? 1 :
                                    T_SEL_MAX_NS / CLK_PERIOD_NS;

    // reset values
    localparam logic                BUSY_RST = 1'b0;
    localparam logic [RESULT_W-1:0] DATA_RST = 18'h00000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01
    } conv_state_t;

    // selector levels as sampled
    typedef struct packed {
        logic bus_width_select;
        logic byte_sel;
    } sel_t;

    // synchronised host strobes, active low as on the pins, and the selector levels
    typedef struct packed {
        logic convert_start_n;
        logic cs_n;
        logic rd_n;
        sel_t sel;
    } pins_t;

    localparam int PINS_W = 5;

    // full word when wide, otherwise upper 16 bits then the low 2 bits
    function automatic logic [RESULT_W-1:0] map_word(
        input logic [RESULT_W-1:0] res,
        input sel_t                sel
    );
        logic [RESULT_W-1:0] w;
        w = res;
        if (!sel.bus_width_select) begin
            if (!sel.byte_sel) begin
                w = {2'b00, res[17:2]};
            end else begin
                w = {2'b00, res[1:0], 14'h0000};
            end
        end
        return w;
    endfunction
endpackage

/* File: verification/host_model.sv */
// host model driving the convert and read strobes
`timescale 1ns/1ps
module host_model (
    // clock
    input  wire logic clk_sys,
    // host strobes and selectors
    output logic      convert_start_n,
    output logic      cs_n,
    output logic      rd_n,
    output logic      byte_sel,
    output logic      bus_width_select
);
    initial begin
        convert_start_n  = 1'b1;
        cs_n             = 1'b1;
        rd_n             = 1'b1;
        byte_sel         = 1'b0;
        bus_width_select = 1'b1;
    end

    task automatic idle(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // chip select first, then a low pulse that ends on its own
    task automatic start();
        @(negedge clk_sys);
        cs_n = 1'b0;
        idle(1);
        convert_start_n = 1'b0;
        fork
            begin
                idle(3);
                convert_start_n = 1'b1;
            end
        join_none
    endtask

    // chip select up, then the acquisition gap
    task automatic finish();
        cs_n = 1'b1;
        idle(16);
    endtask

    // read strobe never ahead of chip select, long after any start
    task automatic read_begin();
        cs_n = 1'b0;
        rd_n = 1'b0;
        byte_sel         = 1'b0;
        bus_width_select = 1'b1;
    endtask

    task automatic select(input logic bw, input logic bs);
        bus_width_select = bw;
        byte_sel         = bs;
        idle(3);
    endtask

    // read strobe low long enough, then high before chip select
    task automatic read_end();
        idle(3);
        rd_n = 1'b1;
    endtask
endmodule

/* File: verification/testbench.sv */
// self-checking bench for the convert and read handshake
`timescale 1ns/1ps
module testbench;
    logic        clk_sys;
    logic        rst_n;
    logic [17:0] sample_data;
    logic        convert_start_n;
    logic        cs_n;
    logic        rd_n;
    logic        byte_sel;
    logic        bus_width_select;
    logic        busy;
    logic [17:0] data_out;
    logic        data_oe;
    logic [17:0] words [9];
    int          error_cnt;
    int          comparisons;
    int          cycles;

    sar_adc_convert_read_handshake i_sar_adc_convert_read_handshake (
        .clk_sys          (clk_sys),
        .rst_n            (rst_n),
        .convert_start_n  (convert_start_n),
        .cs_n             (cs_n),
        .rd_n             (rd_n),
        .byte_sel         (byte_sel),
        .bus_width_select (bus_width_select),
        .sample_data      (sample_data),
        .busy             (busy),
        .data_out         (data_out),
        .data_oe          (data_oe)
    );

    host_model i_host_model (
        .clk_sys          (clk_sys),
        .convert_start_n  (convert_start_n),
        .cs_n             (cs_n),
        .rd_n             (rd_n),
        .byte_sel         (byte_sel),
        .bus_width_select (bus_width_select)
    );

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic tally_and_finish();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [17:0] got, input logic [17:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask

    task automatic wait_busy(input logic val, input int lim);
        int n;
        n = 0;
        while (busy !== val && n < lim) begin
            @(negedge clk_sys);
            n++;
        end
    endtask

    // one full conversion: rise bound and length of the busy pulse
    task automatic t_convert(input logic [17:0] w);
        int c;
        c = 0;
        sample_data = w;
        i_host_model.start();
        wait_busy(1'b1, 3);
        check({17'h0, busy}, 18'h00001);
        while (busy === 1'b1 && c < 40) begin
            @(negedge clk_sys);
            c++;
        end
        check(18'(c), 18'h00020);
        i_host_model.finish();
    endtask

    // second start fall inside the abort window ends the conversion
    task automatic t_abort();
        sample_data = 18'h3ffff;
        i_host_model.start();
        wait_busy(1'b1, 3);
        i_host_model.idle(6);
        i_host_model.start();
        wait_busy(1'b0, 5);
        check({17'h0, busy}, 18'h00000);
        i_host_model.finish();
    endtask

    // chip select falls: too early is ignored, inside the window aborts
    task automatic t_abort_cs();
        i_host_model.start();
        @(negedge clk_sys);
        i_host_model.cs_n = 1'b1;
        @(negedge clk_sys);
        i_host_model.cs_n = 1'b0;
        i_host_model.idle(4);
        check({17'h0, busy}, 18'h00001);
        i_host_model.idle(2);
        i_host_model.cs_n = 1'b1;
        @(negedge clk_sys);
        i_host_model.cs_n = 1'b0;
        wait_busy(1'b0, 5);
        check({17'h0, busy}, 18'h00000);
        i_host_model.finish();
    endtask

    // read one word, on the first also walk the narrow portions
    task automatic t_read(input logic [17:0] w, input bit parts);
        i_host_model.read_begin();
        repeat (4) @(negedge clk_sys);
        check({17'h0, data_oe}, 18'h00001);
        check(data_out, w);
        if (parts) begin
            i_host_model.select(1'b0, 1'b0);
            check(data_out, {2'b00, w[17:2]});
            i_host_model.select(1'b0, 1'b1);
            check(data_out, {2'b00, w[1:0], 14'h0000});
            i_host_model.select(1'b1, 1'b0);
            check(data_out, w);
        end
        i_host_model.read_end();
        repeat (3) @(negedge clk_sys);
        check({17'h0, data_oe}, 18'h00001);
        @(negedge clk_sys);
        check({17'h0, data_oe}, 18'h00000);
        cs_n_up();
    endtask

    task automatic cs_n_up();
        i_host_model.cs_n = 1'b1;
        i_host_model.idle(5);
    endtask

    initial begin
        rst_n       = 1'b0;
        sample_data = 18'h00000;
        error_cnt   = 0;
        comparisons = 0;
        cycles      = 0;
        repeat (10) @(negedge clk_sys);
        check({busy, data_oe, 16'h0000}, 18'h00000);
        check(data_out, 18'h00000);
        rst_n = 1'b1;
        @(negedge clk_sys);
        check({busy, data_oe, 16'h0000}, 18'h00000);
        t_abort();
        t_abort_cs();
        for (int i = 0; i < 9; i++) begin
            words[i] = 18'h3c0f1 ^ (18'(i) * 18'h0a5b7);
            t_convert(words[i]);
        end
        // held word plus full fifo: a further start is refused
        sample_data = 18'h12345;
        i_host_model.start();
        i_host_model.idle(8);
        check({17'h0, busy}, 18'h00000);
        cs_n_up();
        for (int i = 0; i < 9; i++) begin
            t_read(words[i], i == 0);
        end
        tally_and_finish();
    end
endmodule
